// *** rtl/pcg_pkg.sv ***
// constants for the clock gate and lock status block
// assumes one system clock; clock sources arrive as plain inputs
// Notes on behaviour
// - lock output high in lock, low otherwise
// - lock may chatter during acquisition; filter it
// - three post-scale clocks to network or pin
// - gate applied at clock network level
// - re-enable resumes clock at once, no relock
// - gating never disturbs feedback counters or lock
// - enable sampled on falling clock edge
// - each network mux: source select, own enable
package pcg_pkg;
  localparam int unsigned PCG_NUM_OUT  = 3;
  localparam int unsigned PCG_NUM_SRC  = 4;
  localparam int unsigned PCG_SEL_W    = 2;
  localparam int unsigned PCG_DIV_W    = 8;
  localparam int unsigned PCG_LOCK_CYC = 16;
  localparam int unsigned PCG_LCNT_W   = 5;
  localparam logic        PCG_EN_RST   = 1'b0;
  localparam logic [PCG_DIV_W-1:0] PCG_DIV_RST = 8'h01;
  typedef enum logic [1:0] {
    PCG_LK_IDLE = 2'b00,
    PCG_LK_WAIT = 2'b01,
    PCG_LK_HELD = 2'b11
  } pcg_lock_t;
endpackage

// *** rtl/pcg_gate.sv ***
// one clock network mux with its own enable and glitch-free gate
// assumes the enable is valid at the falling edge of the chosen source
module pcg_gate (
  input  wire logic                          rst_i,
  input  wire logic [pcg_pkg::PCG_NUM_SRC-1:0] src_i,
  input  wire logic [pcg_pkg::PCG_SEL_W-1:0]   sel_i,
  input  wire logic                          en_i,
  output logic                               clk_o
);
  logic src_clk;
  logic en_q;

  assign src_clk = src_i[sel_i];

  // enable registered on falling edge, clock stays ungated upstream
  always_ff @(negedge src_clk or posedge rst_i) begin
    if (rst_i) begin
      en_q <= pcg_pkg::PCG_EN_RST;
    end else begin
      en_q <= en_i;
    end
  end

  assign clk_o = src_clk & en_q;
endmodule

// *** rtl/pcg_top.sv ***
// clock control: three post-scale outputs, gating and lock status
// assumes sys_clk_i is the loop reference; lock detect raw from loop
module pcg_top (
  input  wire logic                                   sys_clk_i,
  input  wire logic                                   rst_i,
  input  wire logic [pcg_pkg::PCG_NUM_OUT*pcg_pkg::PCG_DIV_W-1:0] div_i,
  input  wire logic [pcg_pkg::PCG_NUM_OUT-1:0]        route_pin_i,
  input  wire logic [pcg_pkg::PCG_NUM_OUT*pcg_pkg::PCG_SEL_W-1:0] sel_i,
  input  wire logic [pcg_pkg::PCG_NUM_OUT-1:0]        ena_i,
  input  wire logic                                   ext_clk_i,
  input  wire logic                                   lock_raw_i,
  output logic      [pcg_pkg::PCG_NUM_OUT-1:0]        gclk_o,
  output logic      [pcg_pkg::PCG_NUM_OUT-1:0]        pin_clk_o,
  output logic                                        locked_o,
  output logic                                        lock_stable_o
);
  localparam int unsigned N = pcg_pkg::PCG_NUM_OUT;
  localparam int unsigned W = pcg_pkg::PCG_DIV_W;
  localparam int unsigned LW = pcg_pkg::PCG_LCNT_W;
  localparam logic [LW-1:0] LCNT_LAST = LW'(pcg_pkg::PCG_LOCK_CYC - 1);

  logic [N-1:0]   pclk_q;
  logic [N*W-1:0] cnt_q;
  logic [2:0]     lk_sync_q;
  logic [pcg_pkg::PCG_LCNT_W-1:0] lcnt_q;
  pcg_pkg::pcg_lock_t st_q;
  logic [N-1:0]   net_clk;

  // next value of one post-scale count
  function automatic logic [W-1:0] pcg_cnt_inc(input logic [W-1:0] cnt);
    return cnt + W'(1);
  endfunction

  // a divide of zero behaves as one: the count wraps every clock
  function automatic logic pcg_cnt_wrap(input logic [W-1:0] cnt,
                                        input logic [W-1:0] div);
    return pcg_cnt_inc(cnt) >= div;
  endfunction

  // post-scale counters: free running, no gate input touches them
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      pclk_q <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (pcg_cnt_wrap(cnt_q[i*W +: W], div_i[i*W +: W])) begin
          cnt_q[i*W +: W] <= '0;
          pclk_q[i]       <= ~pclk_q[i];
        end else begin
          cnt_q[i*W +: W] <= pcg_cnt_inc(cnt_q[i*W +: W]);
        end
      end
    end
  end

  for (genvar g = 0; g < N; g++) begin : g_net
    pcg_gate u_gate (
      .rst_i (rst_i),
      .src_i ({ext_clk_i, pclk_q}),
      .sel_i (sel_i[g*pcg_pkg::PCG_SEL_W +: pcg_pkg::PCG_SEL_W]),
      .en_i  (ena_i[g]),
      .clk_o (net_clk[g])
    );
    // route each to global network or dedicated pin
    assign gclk_o[g]    = route_pin_i[g] ? 1'b0 : net_clk[g];
    assign pin_clk_o[g] = route_pin_i[g] ? net_clk[g] : 1'b0;
  end

  // raw lock from the detector crosses in with three flops
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lk_sync_q <= '0;
    end else begin
      lk_sync_q <= {lk_sync_q[1:0], lock_raw_i};
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      locked_o <= 1'b0;
    end else if (lk_sync_q[1] == lk_sync_q[2]) begin
      locked_o <= lk_sync_q[2];
    end
  end

  // stable flag: lock must hold a full window before it counts
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q   <= pcg_pkg::PCG_LK_IDLE;
      lcnt_q <= '0;
    end else begin
      case (st_q)
        pcg_pkg::PCG_LK_IDLE: begin
          lcnt_q <= '0;
          if (locked_o) begin
            st_q <= pcg_pkg::PCG_LK_WAIT;
          end
        end
        pcg_pkg::PCG_LK_WAIT: begin
          if (!locked_o) begin
            st_q <= pcg_pkg::PCG_LK_IDLE;
          end else if (lcnt_q == LCNT_LAST) begin
            st_q <= pcg_pkg::PCG_LK_HELD;
          end else begin
            lcnt_q <= lcnt_q + 5'h01;
          end
        end
        pcg_pkg::PCG_LK_HELD: begin
          if (!locked_o) begin
            st_q <= pcg_pkg::PCG_LK_IDLE;
          end
        end
        default: st_q <= pcg_pkg::PCG_LK_IDLE;
      endcase
    end
  end

  assign lock_stable_o = (st_q == pcg_pkg::PCG_LK_HELD);

  AST_LOCK_FOLLOWS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (lk_sync_q[1] && lk_sync_q[2]) |=> locked_o)
    else $error("lock output did not follow settled lock");
  AST_UNLOCK_FOLLOWS: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (!lk_sync_q[1] && !lk_sync_q[2]) |=> !locked_o)
    else $error("lock output did not drop");
  AST_STABLE_NEEDS_RUN: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    $rose(lock_stable_o) |-> $past(locked_o, 16))
    else $error("stable lock flagged too early");
  AST_STABLE_DROPS: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (lock_stable_o && !locked_o) |=> !lock_stable_o)
    else $error("stable lock kept after loss");
  AST_CNT_BOUND: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (div_i[W-1:0] != '0 && $stable(div_i[W-1:0]) &&
     cnt_q[W-1:0] < div_i[W-1:0])
    |=> cnt_q[W-1:0] < div_i[W-1:0])
    else $error("post-scale counter ran past divide");
  AST_CNT_FREE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ($changed(ena_i) && cnt_q[W-1:0] + 8'h01 < div_i[W-1:0]
     && $stable(div_i))
    |=> cnt_q[W-1:0] == $past(cnt_q[W-1:0]) + 8'h01)
    else $error("gate change disturbed counter");
  AST_ROUTE_EXCL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(gclk_o[0] && pin_clk_o[0]))
    else $error("clock driven to both network and pin");
  AST_PIN_ROUTE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    route_pin_i[1] |-> !gclk_o[1])
    else $error("network driven while routed to pin");

  // lock output and its settling filter
  AST_RESET_QUIET: assert property (@(posedge sys_clk_i)
    rst_i |-> (!locked_o && !lock_stable_o))
    else $error("lock outputs high during reset");

  AST_LOCK_RISE_SETTLED: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    $rose(locked_o) |-> $past(lk_sync_q[2]))
    else $error("lock rose without settled lock");

  AST_LOCK_FALL_SETTLED: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    $fell(locked_o) |-> !$past(lk_sync_q[2]))
    else $error("lock fell without settled loss");

  AST_LOCK_HOLD_SPLIT: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (lk_sync_q[1] != lk_sync_q[2]) |=> $stable(locked_o))
    else $error("lock moved on unsettled input");

  AST_IDLE_ARMS: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (st_q == pcg_pkg::PCG_LK_IDLE && locked_o)
    |=> st_q == pcg_pkg::PCG_LK_WAIT)
    else $error("lock did not start the window");

  AST_IDLE_CLEARS: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (st_q == pcg_pkg::PCG_LK_IDLE) |=> (lcnt_q == '0))
    else $error("window count not cleared");

  AST_WAIT_COUNTS: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (st_q == pcg_pkg::PCG_LK_WAIT && locked_o && lcnt_q != LCNT_LAST)
    |=> lcnt_q == $past(lcnt_q) + 5'h01)
    else $error("window count did not advance");

  AST_WAIT_DROPS: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (st_q == pcg_pkg::PCG_LK_WAIT && !locked_o)
    |=> st_q == pcg_pkg::PCG_LK_IDLE)
    else $error("window kept after lock loss");

  AST_WAIT_TO_HELD: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (st_q == pcg_pkg::PCG_LK_WAIT && locked_o && lcnt_q == LCNT_LAST)
    |=> lock_stable_o)
    else $error("stable lock missing after full window");

  AST_HELD_VIA_WAIT: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    $rose(lock_stable_o) |-> $past(st_q) == pcg_pkg::PCG_LK_WAIT)
    else $error("stable lock skipped the window");

  AST_HELD_STAYS: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (lock_stable_o && locked_o) |=> lock_stable_o)
    else $error("stable lock dropped while locked");

  AST_STABLE_NEEDS_LOCK: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    lock_stable_o |-> (locked_o || $past(locked_o)))
    else $error("stable lock without lock");

  AST_LCNT_BOUND: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    lcnt_q <= LCNT_LAST)
    else $error("window count ran past its end");

  // post-scale divider of one toggles every clock
  AST_DIV_ONE_TOGGLE: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (div_i[2*W-1:W] == 8'h01) |=> pclk_q[1] != $past(pclk_q[1]))
    else $error("divide by one did not toggle");

  AST_DIV_ONE_CLEAR: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (div_i[2*W-1:W] == 8'h01) |=> cnt_q[2*W-1:W] == '0)
    else $error("divide by one left a count");
endmodule

// *** testbench/pcg_user.sv ***
// user logic model: counts rising edges of each gated network clock
// assumes clr_i is pulsed by the bench between measurements
module pcg_user (
  input  wire logic [2:0]  clk_i,
  input  wire logic        clr_i,
  output logic      [23:0] cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  for (genvar i = 0; i < 3; i++) begin : g_net
    always @(posedge clk_i[i] or posedge clr_i) begin
      cnt_o[8*i+:8] <= clr_i ? 8'h00 : cnt_o[8*i+:8] + 8'h01;
    end
  end
endmodule

// *** testbench/pcg_top_tb.sv ***
// bench for pcg_top: lock status, gating, routing, external source
// assumes pcg_user counts the gated network clocks
module pcg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i   = 1'b0;
  logic        rst_i       = 1'b0;
  logic [23:0] div_i       = 24'h01_0101;
  logic [2:0]  route_pin_i = 3'h0;
  logic [5:0]  sel_i       = 6'h24;
  logic [2:0]  ena_i       = 3'h0;
  logic        ext_clk_i   = 1'b0;
  logic        lock_raw_i  = 1'b0;
  logic        clr         = 1'b0;
  logic [2:0]  gclk_o;
  logic [2:0]  pin_clk_o;
  logic        locked_o;
  logic        lock_stable_o;
  logic [23:0] cnt;
  int          n_mismatch  = 0;
  int          check_count = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  always #7 ext_clk_i = ~ext_clk_i;
  pcg_top u_pcg_top (.sys_clk_i, .rst_i, .div_i, .route_pin_i, .sel_i,
    .ena_i, .ext_clk_i, .lock_raw_i, .gclk_o, .pin_clk_o, .locked_o,
    .lock_stable_o);
  pcg_user u_pcg_user (.clk_i(gclk_o), .clr_i(clr), .cnt_o(cnt));
  task automatic check(input string nm, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic restart;
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_lock;
    lock_raw_i = 1'b1;
    cyc(1);
    lock_raw_i = 1'b0;
    cyc(6);
    check("short pulse", 1'b0, locked_o);
    lock_raw_i = 1'b1;
    cyc(4);
    check("locked", 1'b1, locked_o);
    cyc(15);
    check("early stable", 1'b0, lock_stable_o);
    cyc(2);
    check("stable", 1'b1, lock_stable_o);
    lock_raw_i = 1'b0;
    cyc(4);
    check("unlocked", 1'b0, locked_o);
    lock_raw_i = 1'b1;
    cyc(3);
    check("stable dropped", 1'b0, lock_stable_o);
  endtask
  task automatic t_gate;
    restart();
    cyc(10);
    check("gated off", 1'b1, cnt === 24'h00_0000);
    ena_i = 3'h7;
    cyc(3);
    check("net0 on", 1'b1, cnt[7:0] != 8'h00);
    check("net1 on", 1'b1, cnt[15:8] != 8'h00);
    check("net2 on", 1'b1, cnt[23:16] != 8'h00);
    check("still locked", 1'b1, locked_o);
  endtask
  task automatic t_route;
    int hi;
    hi = 0;
    route_pin_i = 3'h2;
    restart();
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      hi += int'(pin_clk_o[1]);
    end
    check("net1 idle", 1'b1, cnt[15:8] == 8'h00);
    check("pin runs", 1'b1, hi > 0);
  endtask
  task automatic t_ext;
    div_i = 24'h01_01ff;
    sel_i = 6'h27;
    restart();
    cyc(10);
    check("ext source", 1'b1, cnt[7:0] > 8'h02);
  endtask
  initial begin
    #5us;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    #1;
    rst_i = 1'b1;
    cyc(12);
    check("reset lock", 1'b0, locked_o);
    rst_i = 1'b0;
    t_lock();
    t_gate();
    t_route();
    t_ext();
    give_verdict();
  end
endmodule
